// [hdl/fdtt_track_timing.sv]
// Command interpreter slice for the track-set and timing-parameter commands,
// with the motor delay timers and the step interval timer they program.
// Assumes command bytes, result reads and context arrive from logic on clk.
//
// Behaviour
// - Track-set takes opcode, drive/byte select, track byte.
// - Read form returns stored byte, third byte ignored.
// - Write form stores third byte into selected byte.
// - Drive field decode honours four-drive and swap.
// - Byte select picks low or high track byte.
// - Wide mode keeps 12 bits, host writes twice.
// - Track-set yields exactly one result byte.
// - Timing command takes opcode, step/after, before/mode.
// - Timing parameters undefined at power-up, reset-immune.
// - Timing command: no interrupt, no result phase.
// - Delay after is factor times constant, 0=16.
// - Delay-after constants per rate and timer scale.
// - Delay-before constants per rate and timer scale.
// - Motor timer scale picks constant group.
// - Step interval is (16-code) ms, rate scaled.
// - Third byte bit 0 selects DMA or non-DMA.
// - Delays sit around motor select and deselect.
// - Delay-before factor 0 is treated as 128.

`timescale 1ns/1ps

module fdtt_track_timing
  import fdtt_pkg::*;
#(
  parameter int unsigned CLK_KHZ = fdtt_pkg::CLK_KHZ_DEF
)
(
  input  wire  logic                       clk,
  input  wire  logic                       rst_b,
  input  wire  logic                       cmd_valid,
  input  wire  logic [7:0]                 cmd_byte,
  input  wire  logic                       res_read,
  input  wire  fdtt_pkg::fdtt_ctx_t        ctx,
  input  wire  logic                       motor_select,
  input  wire  logic                       cmd_end,
  input  wire  logic                       seek_active,
  output logic                             cmd_busy_ff,
  output logic                             res_valid_ff,
  output logic [7:0]                       res_byte_ff,
  output fdtt_pkg::fdtt_track_t            present_track_ff [fdtt_pkg::NUM_DRIVES],
  output fdtt_pkg::fdtt_timing_t           timing_ff,
  output logic                             rw_start_ok_ff,
  output logic                             motor_deselect_ff,
  output logic                             step_pulse_ff
);

  import fdtt_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TRK_SEL,
    ST_TRK_DATA,
    ST_TIM_B2,
    ST_TIM_B3,
    ST_RESULT
  } fdtt_state_t;

  fdtt_state_t state_ff;
  logic        wr_flag_ff;
  logic        hi_sel_ff;
  logic [1:0]  drive_ff;
  logic        drive_ok_ff;
  logic [31:0] bef_cnt_ff;
  logic        bef_run_ff;
  logic [31:0] aft_cnt_ff;
  logic        aft_run_ff;
  logic [31:0] step_cnt_ff;
  logic        seek_seen_ff;

  // Cycles per delay-constant unit, rounded up since delays are minimums
  function automatic logic [31:0] dly_unit(input logic after, input logic scale, input logic [1:0] rate);
    longint unsigned num;
    num = after ? AFT_NUM[scale][rate] : BEF_NUM[scale][rate];
    return 32'((num * CLK_KHZ + DLY_DEN[rate] - 1) / DLY_DEN[rate]);
  endfunction

  // Step interval in cycles, never below one
  function automatic logic [31:0] step_cycles(input logic [3:0] code, input logic [1:0] rate);
    longint unsigned ms;
    longint unsigned cyc;
    ms  = longint'(STEP_BASE_MS) - longint'(code);
    cyc = (ms * CLK_KHZ * STEP_NUM[rate]) / STEP_DEN[rate];
    return (cyc == 0) ? CNT_ONE : 32'(cyc);
  endfunction

  // Zero factor substitution: 16 for after, 128 for before
  function automatic logic [7:0] eff_factor(input logic after, input logic [6:0] f);
    if (f == '0)
    begin
      return after ? AFT_ZERO_FACTOR : BEF_ZERO_FACTOR;
    end
    return {1'b0, f};
  endfunction

  // Drive field legality depends on drive count and exchange
  function automatic logic drive_legal(input logic [1:0] d, input fdtt_ctx_t c);
    if (d == 2'h2)
    begin
      return c.four_drive_en | c.drive_swap;
    end
    else if (d == 2'h3)
    begin
      return c.four_drive_en;
    end
    return 1'b1;
  endfunction

  // Command phase sequencing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff    <= ST_IDLE;
      wr_flag_ff  <= 1'b0;
      hi_sel_ff   <= 1'b0;
      drive_ff    <= 2'h0;
      drive_ok_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (cmd_valid)
          begin
            if ({cmd_byte[7], cmd_byte[5:0]} == OPC_TRACK_SET)
            begin
              wr_flag_ff <= cmd_byte[OPC_WRITE_BIT];
              state_ff   <= ST_TRK_SEL;
            end
            else if (cmd_byte == OPC_TIMING)
            begin
              state_ff <= ST_TIM_B2;
            end
          end
        end
        ST_TRK_SEL:
        begin
          if (cmd_valid)
          begin
            hi_sel_ff   <= cmd_byte[TRK_HI_SEL_BIT];
            drive_ff    <= cmd_byte[DRV_MSB:0];
            drive_ok_ff <= drive_legal(cmd_byte[DRV_MSB:0], ctx);
            state_ff    <= ST_TRK_DATA;
          end
        end
        ST_TRK_DATA:
        begin
          if (cmd_valid)
          begin
            state_ff <= ST_RESULT;
          end
        end
        ST_TIM_B2:
        begin
          if (cmd_valid)
          begin
            state_ff <= ST_TIM_B3;
          end
        end
        ST_TIM_B3:
        begin
          if (cmd_valid)
          begin
            state_ff <= ST_IDLE;
          end
        end
        ST_RESULT:
        begin
          if (res_read)
          begin
            state_ff <= ST_IDLE;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_busy_ff <= 1'b0;
    end
    else
    begin
      cmd_busy_ff <= (state_ff != ST_IDLE) || (cmd_valid && ({cmd_byte[7], cmd_byte[5:0]} == OPC_TRACK_SET
                     || cmd_byte == OPC_TIMING)) ? !(state_ff == ST_TIM_B3 && cmd_valid)
                     && !(state_ff == ST_RESULT && res_read) : 1'b0;
    end
  end

  // Present-track storage, one 12-bit value per logical drive
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_DRIVES; i++)
      begin
        present_track_ff[i] <= TRACK_W'(TRK_RESET);
      end
    end
    else if (state_ff == ST_TRK_DATA && cmd_valid && wr_flag_ff && drive_ok_ff)
    begin
      if (hi_sel_ff)
      begin
        // only the low nibble is kept
        present_track_ff[drive_ff][TRACK_W-1:8] <= cmd_byte[3:0];
      end
      else
      begin
        present_track_ff[drive_ff][7:0] <= cmd_byte;
        // narrow mode clears the high nibble on a low-byte write
        if (!ctx.wide_track_mode)
        begin
          present_track_ff[drive_ff][TRACK_W-1:8] <= 4'h0;
        end
      end
    end
  end

  // Result byte: one per track-set, no interrupt raised
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      res_valid_ff <= 1'b0;
      res_byte_ff  <= TRK_RESET;
    end
    else if (state_ff == ST_TRK_DATA && cmd_valid)
    begin
      res_valid_ff <= 1'b1;
      if (!drive_ok_ff)
      begin
        res_byte_ff <= TRK_RESET;
      end
      else if (wr_flag_ff)
      begin
        res_byte_ff <= hi_sel_ff ? {4'h0, cmd_byte[3:0]} : cmd_byte;
      end
      // read form ignores the dummy byte
      else
      begin
        res_byte_ff <= hi_sel_ff ? {4'h0, present_track_ff[drive_ff][TRACK_W-1:8]}
                                 : present_track_ff[drive_ff][7:0];
      end
    end
    else if (state_ff == ST_RESULT && res_read)
    begin
      res_valid_ff <= 1'b0;
    end
  end

  // no reset on the timing parameters
  always_ff @(posedge clk)
  begin
    if (cmd_valid && state_ff == ST_TIM_B2)
    begin
      timing_ff.step_interval_code     <= cmd_byte[STEP_MSB:STEP_LSB];
      timing_ff.delay_after_processing <= cmd_byte[AFT_MSB:0];
    end
    if (cmd_valid && state_ff == ST_TIM_B3)
    begin
      timing_ff.delay_before_processing <= cmd_byte[BEF_MSB:BEF_LSB];
      timing_ff.non_dma                 <= cmd_byte[NON_DMA_BIT];
    end
  end

  // Delay before processing: motor select to read/write start
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bef_cnt_ff     <= CNT_ZERO;
      bef_run_ff     <= 1'b0;
      rw_start_ok_ff <= 1'b0;
    end
    else
    begin
      rw_start_ok_ff <= 1'b0;
      if (motor_select)
      begin
        bef_run_ff <= 1'b1;
        bef_cnt_ff <= 32'(eff_factor(1'b0, timing_ff.delay_before_processing))
                      * dly_unit(1'b0, ctx.motor_timer_scale, ctx.data_rate);
      end
      else if (bef_run_ff)
      begin
        if (bef_cnt_ff <= CNT_ONE)
        begin
          bef_run_ff     <= 1'b0;
          rw_start_ok_ff <= 1'b1;
        end
        else
        begin
          bef_cnt_ff <= bef_cnt_ff - CNT_ONE;
        end
      end
    end
  end

  // Delay after processing: command end to motor deselect
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aft_cnt_ff        <= CNT_ZERO;
      aft_run_ff        <= 1'b0;
      motor_deselect_ff <= 1'b0;
    end
    else
    begin
      motor_deselect_ff <= 1'b0;
      if (cmd_end)
      begin
        aft_run_ff <= 1'b1;
        aft_cnt_ff <= 32'(eff_factor(1'b1, {3'h0, timing_ff.delay_after_processing}))
                      * dly_unit(1'b1, ctx.motor_timer_scale, ctx.data_rate);
      end
      // A new motor selection abandons a pending deselect
      else if (motor_select)
      begin
        aft_run_ff <= 1'b0;
      end
      else if (aft_run_ff)
      begin
        if (aft_cnt_ff <= CNT_ONE)
        begin
          aft_run_ff        <= 1'b0;
          motor_deselect_ff <= 1'b1;
        end
        else
        begin
          aft_cnt_ff <= aft_cnt_ff - CNT_ONE;
        end
      end
    end
  end

  // Step pulses, one interval apart, while the seek logic asks
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      step_cnt_ff   <= CNT_ZERO;
      seek_seen_ff  <= 1'b0;
      step_pulse_ff <= 1'b0;
    end
    else
    begin
      seek_seen_ff  <= seek_active;
      step_pulse_ff <= 1'b0;
      if (!seek_active)
      begin
        step_cnt_ff <= CNT_ZERO;
      end
      else if (!seek_seen_ff || step_cnt_ff <= CNT_ONE)
      begin
        step_cnt_ff   <= step_cycles(timing_ff.step_interval_code, ctx.data_rate);
        // First pulse leads; later ones end each interval
        step_pulse_ff <= 1'b1;
      end
      else
      begin
        step_cnt_ff <= step_cnt_ff - CNT_ONE;
      end
    end
  end

endmodule // fdtt_track_timing

// [inc/fdtt_pkg.sv]
// Constants and carrier types for the track-set and timing-parameter unit.
// Assumes the surrounding controller hands over whole command bytes on clk.
package fdtt_pkg;

  // Opcodes: track-set compares bit 7 and bits 5:0, bit 6 is the write flag
  localparam logic [6:0] OPC_TRACK_SET   = 7'h21;
  localparam logic [7:0] OPC_TIMING      = 8'h03;
  localparam int         OPC_WRITE_BIT   = 6;

  // Track-set second byte fields
  localparam int         TRK_HI_SEL_BIT  = 2;
  localparam int         DRV_MSB         = 1;

  // Timing-parameter byte fields
  localparam int         STEP_MSB        = 7;
  localparam int         STEP_LSB        = 4;
  localparam int         AFT_MSB         = 3;
  localparam int         BEF_MSB         = 7;
  localparam int         BEF_LSB         = 1;
  localparam int         NON_DMA_BIT     = 0;

  // Zero factors stand for these values
  localparam logic [7:0] AFT_ZERO_FACTOR = 8'h10;
  localparam logic [7:0] BEF_ZERO_FACTOR = 8'h80;
  localparam logic [4:0] STEP_BASE_MS    = 5'h10;

  // Data rate codes from the controller's rate select
  localparam logic [1:0] RATE_500K       = 2'h0;
  localparam logic [1:0] RATE_300K       = 2'h1;
  localparam logic [1:0] RATE_250K       = 2'h2;
  localparam logic [1:0] RATE_1M         = 2'h3;

  // Clock in kHz, i.e. cycles per millisecond at 10 MHz
  localparam int unsigned CLK_KHZ_DEF    = 10000;

  // Delay constants in ms as num/den, indexed [motor_timer_scale][rate code]
  localparam int unsigned AFT_NUM [2][4] = '{'{16, 80, 32, 8}, '{512, 2560, 1024, 512}};
  localparam int unsigned BEF_NUM [2][4] = '{'{1, 10, 4, 1}, '{32, 160, 64, 32}};
  localparam int unsigned DLY_DEN [4]    = '{1, 3, 1, 1};
  // Step interval multiplier per rate code, as num/den
  localparam int unsigned STEP_NUM [4]   = '{1, 167, 2, 1};
  localparam int unsigned STEP_DEN [4]   = '{1, 100, 1, 2};

  localparam int          TRACK_W        = 12;
  localparam int          NUM_DRIVES     = 4;
  localparam logic [7:0]  TRK_RESET      = 8'h00;
  localparam logic [31:0] CNT_ZERO       = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE        = 32'h0000_0001;

  typedef logic [TRACK_W-1:0] fdtt_track_t;

  // Timing parameters as loaded by the timing-parameter command
  typedef struct packed {
    logic [3:0] step_interval_code;
    logic [3:0] delay_after_processing;
    logic [6:0] delay_before_processing;
    logic       non_dma;
  } fdtt_timing_t;

  // Controller context that steers both delays and the step rate
  typedef struct packed {
    logic       wide_track_mode;
    logic       motor_timer_scale;
    logic [1:0] data_rate;
    logic       four_drive_en;
    logic       drive_swap;
  } fdtt_ctx_t;

endpackage

// [testbench/fdtt_chk.sv]
// Assertions for the track-set and timing unit.
// Bound to fdtt_track_timing; CLK_KHZ is cycles per millisecond.
`timescale 1ns/1ps
module fdtt_chk
  import fdtt_pkg::*;
#(
  parameter int unsigned CLK_KHZ = 10
)
(
  input logic         clk,
  input logic         rst_b,
  input logic         cmd_valid,
  input logic [7:0]   cmd_byte,
  input logic         res_read,
  input fdtt_ctx_t    ctx,
  input logic         motor_select,
  input logic         cmd_end,
  input logic         seek_active,
  input logic         res_valid_ff,
  input logic [7:0]   res_byte_ff,
  input fdtt_track_t  present_track_ff [NUM_DRIVES],
  input fdtt_timing_t timing_ff,
  input logic         rw_start_ok_ff,
  input logic         motor_deselect_ff,
  input logic         step_pulse_ff
);
  // The pulse is registered on the last count, so it is sampled one cycle later
  localparam int BEF_N = CLK_KHZ + 1;
  localparam int AFT_N = 16 * CLK_KHZ + 1;
  logic [7:0] b1_ff;
  logic [7:0] b2_ff;
  logic [7:0] b3_ff;
  logic       base_ok;

  // Last three bytes; at a rising result they are opcode, select, track
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      {b3_ff, b2_ff, b1_ff} <= 24'h000000;
    else if (cmd_valid)
      {b3_ff, b2_ff, b1_ff} <= {b2_ff, b1_ff, cmd_byte};
  end
  assign base_ok = ctx.data_rate == RATE_500K && !ctx.motor_timer_scale;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_res_hold;
    res_valid_ff && !res_read |=> res_valid_ff && $stable(res_byte_ff);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("result lost");
  property p_res_clr;
    res_valid_ff && res_read |=> !res_valid_ff;
  endproperty
  a_res_clr: assert property (p_res_clr) else $error("result stuck");
  property p_wr_echo;
    $rose(res_valid_ff) && b3_ff[6] && !b2_ff[1]
      |-> res_byte_ff == (b2_ff[2] ? {4'h0, b1_ff[3:0]} : b1_ff);
  endproperty
  a_wr_echo: assert property (p_wr_echo) else $error("bad echo");
  property p_wr_store;
    $rose(res_valid_ff) && b3_ff[6] && b2_ff[2:1] == 2'h0
      |-> present_track_ff[b2_ff[0]][7:0] == b1_ff;
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("not stored");
  property p_rd_keep;
    // Fixed indices: a shifting index would be re-read a cycle back by $stable
    $rose(res_valid_ff) && !b3_ff[6] |-> $stable(present_track_ff[0]) && $stable(present_track_ff[1])
      && $stable(present_track_ff[2]) && $stable(present_track_ff[3])
      && (b2_ff[2:1] != 2'h0 || res_byte_ff == present_track_ff[b2_ff[0]][7:0]);
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("bad read");
  property p_before;
    motor_select && base_ok && timing_ff.delay_before_processing == 7'h01 |-> ##BEF_N rw_start_ok_ff;
  endproperty
  a_before: assert property (p_before) else $error("start delay");
  property p_after;
    cmd_end && base_ok && timing_ff.delay_after_processing == 4'h1 |-> ##AFT_N motor_deselect_ff;
  endproperty
  a_after: assert property (p_after) else $error("stop delay");
  property p_step_first;
    $rose(seek_active) |=> step_pulse_ff;
  endproperty
  a_step_first: assert property (p_step_first) else $error("no step");
  property p_step_gap;
    step_pulse_ff && seek_active && ctx.data_rate == RATE_500K && timing_ff.step_interval_code == 4'hF
      |=> !step_pulse_ff [*8] ##2 (step_pulse_ff || !seek_active);
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("step gap");
  c_res: cover property ($rose(res_valid_ff));
  c_start: cover property (rw_start_ok_ff);
  c_stop: cover property (motor_deselect_ff);
endmodule // fdtt_chk

bind fdtt_track_timing fdtt_chk #(.CLK_KHZ(CLK_KHZ)) fdtt_chk_i (
  .clk, .rst_b, .cmd_valid, .cmd_byte, .res_read, .ctx, .motor_select, .cmd_end, .seek_active,
  .res_valid_ff, .res_byte_ff, .present_track_ff, .timing_ff, .rw_start_ok_ff, .motor_deselect_ff,
  .step_pulse_ff);

// [testbench/fdtt_host.sv]
// Host model that writes three-byte commands into the unit.
// Tasks are called just after a rising clk edge.
`timescale 1ns/1ps
module fdtt_host
(
  input  logic       clk,
  output logic       cmd_valid,
  output logic [7:0] cmd_byte
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
  end
  task automatic send3(input logic [7:0] b0, b1, b2, input int gap);
    logic [7:0] q [3];
    q = '{b0, b1, b2};
    foreach (q[i])
    begin
      cmd_valid = 1'b1;
      cmd_byte  = q[i];
      @(posedge clk);
      #1;
      if (gap != 0 || i == 2)
      begin
        // Released bus shows the inverse, never a stale byte
        cmd_valid = 1'b0;
        cmd_byte  = ~q[i];
        repeat (gap)
        begin
          @(posedge clk);
          #1;
        end
      end
    end
  endtask
endmodule // fdtt_host

// [testbench/tb.sv]
// Self-checking bench for the track-set and timing unit.
// Runs the unit with CLK_KHZ 10 so each millisecond is ten cycles.
`timescale 1ns/1ps
module tb;
  import fdtt_pkg::*;
  logic         clk;
  logic         rst_b;
  logic         cmd_valid;
  logic [7:0]   cmd_byte;
  logic         res_read;
  fdtt_ctx_t    ctx;
  logic         motor_select;
  logic         cmd_end;
  logic         seek_active;
  logic         cmd_busy_ff;
  logic         res_valid_ff;
  logic [7:0]   res_byte_ff;
  fdtt_track_t  present_track_ff [NUM_DRIVES];
  fdtt_timing_t timing_ff;
  logic         rw_start_ok_ff;
  logic         motor_deselect_ff;
  logic         step_pulse_ff;
  logic [3:0]   flags;
  int           failures;
  int           comparisons;

  fdtt_host fdtt_host_i (.clk, .cmd_valid, .cmd_byte);
  fdtt_track_timing #(.CLK_KHZ(10)) fdtt_track_timing_i (
    .clk, .rst_b, .cmd_valid, .cmd_byte, .res_read, .ctx, .motor_select, .cmd_end, .seek_active,
    .cmd_busy_ff, .res_valid_ff, .res_byte_ff, .present_track_ff, .timing_ff, .rw_start_ok_ff,
    .motor_deselect_ff, .step_pulse_ff);
  assign flags = {res_valid_ff, step_pulse_ff, motor_deselect_ff, rw_start_ok_ff};
  always #50 clk = ~clk;

  task automatic final_report;
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Counts cycles until a flag rises; a hang ends the run
  task automatic wait_for(input int sel, lim, output int n);
    n = 0;
    while (flags[sel] !== 1'b1)
    begin
      tick(1);
      n++;
      if (n > lim)
      begin
        failures++;
        final_report();
      end
    end
  endtask
  task automatic tim(input logic [7:0] b2, b3);
    fdtt_host_i.send3(8'h03, b2, b3, 1);
    tick(1);
    chk(timing_ff, {b2, b3});
    chk(16'(res_valid_ff), 16'h0000);
    chk(16'(cmd_busy_ff), 16'h0000);
  endtask
  task automatic dly(input logic aft, input int exp);
    int n;
    motor_select = !aft;
    cmd_end = aft;
    tick(1);
    motor_select = 1'b0;
    cmd_end = 1'b0;
    wait_for(aft ? 1 : 0, exp + 4, n);
    chk(16'(n), 16'(exp));
    tick(2);
  endtask
  task automatic stp(input int exp);
    int n;
    seek_active = 1'b1;
    wait_for(2, 4, n);
    chk(16'(n), 16'h0001);
    tick(1);
    wait_for(2, exp + 4, n);
    chk(16'(n + 1), 16'(exp));
    seek_active = 1'b0;
    tick(2);
  endtask
  task automatic tset(input logic wr, input logic [7:0] b2, b3, exp);
    int n;
    fdtt_host_i.send3({1'b0, wr, 6'h21}, b2, b3, 0);
    wait_for(3, 4, n);
    chk(16'(res_byte_ff), 16'(exp));
    chk(16'(cmd_busy_ff), 16'h0001);
    res_read = 1'b1;
    tick(1);
    res_read = 1'b0;
    tick(1);
    chk(16'(res_valid_ff), 16'h0000);
    chk(16'(cmd_busy_ff), 16'h0000);
  endtask

  task automatic s_timers;
    ctx = '{1'b1, 1'b0, RATE_500K, 1'b1, 1'b0};
    tim(8'hF1, 8'h03);
    dly(1'b0, 10);
    dly(1'b1, 160);
    stp(10);
    ctx.data_rate = RATE_1M;
    tim(8'hE0, 8'h00);
    dly(1'b0, 1280);
    dly(1'b1, 1280);
    stp(10);
    ctx = '{1'b1, 1'b1, RATE_300K, 1'b1, 1'b0};
    tim(8'h01, 8'h02);
    dly(1'b0, 534);
    dly(1'b1, 8534);
    stp(267);
    ctx.motor_timer_scale = 1'b0;
    dly(1'b1, 267);
    ctx.data_rate = RATE_250K;
    dly(1'b0, 40);
  endtask
  task automatic s_tracks;
    for (int d = 0; d < 4; d++)
    begin
      tset(1'b1, 8'h30 | 8'(d), 8'h10 + 8'(d), 8'h10 + 8'(d));
      tset(1'b1, 8'h34 | 8'(d), 8'hC0 | 8'(d), 8'(d));
      tset(1'b0, 8'h30 | 8'(d), 8'hEE, 8'h10 + 8'(d));
      tset(1'b0, 8'h34 | 8'(d), 8'hEE, 8'(d));
      chk(16'(present_track_ff[d]), {4'h0, 4'(d), 8'h10 + 8'(d)});
    end
  endtask
  task automatic s_drives;
    ctx = '{1'b1, 1'b0, RATE_500K, 1'b0, 1'b0};
    tset(1'b1, 8'h32, 8'h55, 8'h00);
    chk(16'(present_track_ff[2]), 16'h0212);
    ctx.drive_swap = 1'b1;
    tset(1'b1, 8'h32, 8'h55, 8'h55);
    chk(16'(present_track_ff[2]), 16'h0255);
    tset(1'b1, 8'h33, 8'h66, 8'h00);
    chk(16'(present_track_ff[3]), 16'h0313);
    ctx.wide_track_mode = 1'b0;
    tset(1'b1, 8'h31, 8'h42, 8'h42);
    chk(16'(present_track_ff[1]), 16'h0042);
  endtask
  task automatic s_reset;
    fdtt_timing_t keep;
    keep = timing_ff;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(1);
    chk(timing_ff, keep);
    chk(16'(present_track_ff[1]), 16'h0000);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    res_read = 1'b0;
    ctx = '{1'b0, 1'b0, RATE_500K, 1'b0, 1'b0};
    motor_select = 1'b0;
    cmd_end = 1'b0;
    seek_active = 1'b0;
    failures = 0;
    comparisons = 0;
    tick(16);
    rst_b = 1'b1;
    s_timers();
    s_tracks();
    s_drives();
    s_reset();
    final_report();
  end
endmodule // tb
